// File: design/scan_bridge_pkg.sv
// Purpose: Shared constants and types for the scan bridge and its test master
// Assumes: Both ends run on one 10 MHz system clock
// Notes:   Instruction codes other than the identification code are local picks
package scan_bridge_pkg;

  // ****************************************
  // TAP controller states
  // ****************************************
  typedef enum logic [3:0] {
    st_tlr, st_rti, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr,
    st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_upd_ir
  } tap_state_e;

  typedef enum logic [1:0] {
    pc_parked, pc_wait_idle, pc_wait_sync, pc_active
  } port_state_e;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [7:0] ID_CODE_INSTR                = 8'hAA;
  localparam logic [7:0] BYPASS_INSTR                 = 8'hFF;
  localparam logic [7:0] COUNTER_ENABLE_INSTR         = 8'h10;
  localparam logic [7:0] COUNTER_DISABLE_INSTR        = 8'h11;
  localparam logic [7:0] COUNTER_SELECT_INSTR         = 8'h12;
  localparam logic [7:0] PARK_IN_IDLE_INSTR           = 8'h20;
  localparam logic [7:0] PARK_IN_RESET_INSTR          = 8'h21;
  localparam logic [7:0] PARK_IN_PAUSE_DR_INSTR       = 8'h22;
  localparam logic [7:0] PARK_IN_PAUSE_IR_INSTR       = 8'h23;
  localparam logic [7:0] RELEASE_INSTR                = 8'h24;
  localparam logic [7:0] LOCAL_PORTS_RESET_INSTR      = 8'h30;
  localparam logic [7:0] CONFIG_REGISTER_SELECT_INSTR = 8'h40;
  localparam logic [7:0] GROUP_SELECT_INSTR           = 8'h41;
  localparam logic [7:0] IR_CAPTURE                   = 8'h01;

  // ****************************************
  // Initial values and field positions
  // ****************************************
  localparam logic [1:0]  GROUP_RST = 2'h0;
  localparam logic [7:0]  INSTR_RST = ID_CODE_INSTR;
  localparam logic [7:0]  MODE_RST  = 8'h01;
  localparam logic [15:0] LFSR_RST  = 16'h0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam int MODE_TCK_STOP_BIT  = 3;
  localparam int MODE_LOOPBACK_BIT  = 4;
  localparam int MODE_DONE_BIT      = 7;

  // ****************************************
  // Test master clock and registers
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int TCK_PERIOD_NS  = 800;
  localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] REG_TMS    = 8'h00;
  localparam logic [7:0] REG_TDI    = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_TDO    = 8'h10;
  localparam int CTRL_START_BIT = 8;
  localparam int CTRL_TRST_BIT  = 9;

  function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
    unique case (s)
      st_tlr:    tap_next = tms ? st_tlr    : st_rti;
      st_rti:    tap_next = tms ? st_sel_dr : st_rti;
      st_sel_dr: tap_next = tms ? st_sel_ir : st_cap_dr;
      st_cap_dr: tap_next = tms ? st_ex1_dr : st_sh_dr;
      st_sh_dr:  tap_next = tms ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: tap_next = tms ? st_upd_dr : st_pa_dr;
      st_pa_dr:  tap_next = tms ? st_ex2_dr : st_pa_dr;
      st_ex2_dr: tap_next = tms ? st_upd_dr : st_sh_dr;
      st_upd_dr: tap_next = tms ? st_sel_dr : st_rti;
      st_sel_ir: tap_next = tms ? st_tlr    : st_cap_ir;
      st_cap_ir: tap_next = tms ? st_ex1_ir : st_sh_ir;
      st_sh_ir:  tap_next = tms ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: tap_next = tms ? st_upd_ir : st_pa_ir;
      st_pa_ir:  tap_next = tms ? st_ex2_ir : st_pa_ir;
      st_ex2_ir: tap_next = tms ? st_upd_ir : st_sh_ir;
      st_upd_ir: tap_next = tms ? st_sel_dr : st_rti;
    endcase
  endfunction

endpackage

// File: design/scan_link_if.sv
// Purpose: Backplane and local scan port wires between master and bridge
// Assumes: All pins are point to point, no tristate
// Notes:   Local port pins are only read by the bench
`timescale 1ns/1ns
interface scan_link_if #(parameter int NUM_PORTS = 3);
  logic                 tck;
  logic                 tms;
  logic                 tdi;
  logic                 tdo;
  logic                 trst_n;
  logic [NUM_PORTS-1:0] tck_l;
  logic [NUM_PORTS-1:0] tms_l;

  modport bridge (input tck, input tms, input tdi, input trst_n,
                  output tdo, output tck_l, output tms_l);
  modport master (output tck, output tms, output tdi, output trst_n, input tdo);
endinterface

// File: design/scan_bridge_local_port_control.sv
// Purpose: Bridge TAP with self-test counter, reset levels and local port parking
// Assumes: Backplane pins are sampled by clk_in, well above the test clock rate
// Notes:   Address matching is not modelled; the bridge always acts as selected
// Operation
// - Master orders self-test steps, then loads count
// - Test-Logic-Reset clears the down-counter
// - Config register bit 7 shows terminal count
// - Master disables counter before releasing port
// - Self test starts after Update-DR edge
// - Test-Logic-Reset resets registers and local chains
// - Reset by five TMS-high clocks or pin
// - Level-one reset restores all initial values
// - Initial values: group, instruction, mode, LFSR, counter
// - Local reset instruction drives all local TMS high
// - Park-in-reset parks selected port in reset
// - Master releases non-reset parked port before reset
// - Idle ports park in one of four states
// - Local TMS held high while parked
// - Released port waits for matching sync state
// - Reset-parked ports get TMS low on falling edge
// - Bridge in Run-Test/Idle connects local TMS
// - Otherwise local TMS stays low until idle
// - One controller per port, chosen by mode bits
// - Each port activates at its own sync state
// - Terminal count stops parked local clocks low
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ns
module scan_bridge_local_port_control
  import scan_bridge_pkg::*;
#(
  parameter int          NUM_PORTS = 3,
  parameter logic [31:0] ID_VALUE  = 32'h1234_5001  // Arbitrary identification value
) (
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  scan_link_if.bridge               link,
  output logic [7:0]                instr_out,
  output logic [7:0]                mode_out,
  output logic [NUM_PORTS-1:0]      port_active_out
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic       tck_prev_q;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       trst_n_s;
  logic       rise;
  logic       fall;

  assign tck_s    = s2_q[0];
  assign tms_s    = s2_q[1];
  assign tdi_s    = s2_q[2];
  assign trst_n_s = s2_q[3];
  assign rise     = tck_s & ~tck_prev_q;
  assign fall     = ~tck_s & tck_prev_q;

  // ****************************************
  // State
  // ****************************************
  tap_state_e           tap_q,    tap_d;
  logic [7:0]           ir_q,     ir_d;
  logic [7:0]           irs_q,    irs_d;
  logic [31:0]          dr_q,     dr_d;
  logic [7:0]           mode_q,   mode_d;
  logic [1:0]           group_q,  group_d;
  logic [15:0]          lfsr_q,   lfsr_d;
  logic [31:0]          cnt_q,    cnt_d;
  logic                 cnt_en_q, cnt_en_d;
  logic                 run_q,    run_d;
  logic                 tdo_q,    tdo_d;
  port_state_e          pc_q      [NUM_PORTS];
  port_state_e          pc_d      [NUM_PORTS];
  tap_state_e           park_q    [NUM_PORTS];
  tap_state_e           park_d    [NUM_PORTS];
  logic [NUM_PORTS-1:0] hold_q,   hold_d;
  logic [NUM_PORTS-1:0] tms_l_q,  tms_l_d;
  logic [NUM_PORTS-1:0] tck_l_q,  tck_l_d;
  logic                 done;
  logic [NUM_PORTS-1:0] sel;

  function automatic int unsigned dr_len(input logic [7:0] ir);
    unique case (ir)
      ID_CODE_INSTR, COUNTER_SELECT_INSTR: dr_len = 32;
      CONFIG_REGISTER_SELECT_INSTR:        dr_len = 8;
      GROUP_SELECT_INSTR:                  dr_len = 2;
      default:                             dr_len = 1;
    endcase
  endfunction

  assign done = cnt_en_q & run_q & (cnt_q == COUNT_RST);
  assign sel  = mode_q[MODE_LOOPBACK_BIT] ? '0 : mode_q[NUM_PORTS-1:0];

  always_comb begin
    tap_d    = rise ? tap_next(tap_q, tms_s) : tap_q;
    ir_d     = ir_q;
    irs_d    = irs_q;
    dr_d     = dr_q;
    mode_d   = mode_q;
    group_d  = group_q;
    lfsr_d   = lfsr_q;
    cnt_d    = cnt_q;
    cnt_en_d = cnt_en_q;
    run_d    = run_q;
    tdo_d    = tdo_q;
    pc_d     = pc_q;
    park_d   = park_q;
    hold_d   = hold_q;
    if (!trst_n_s) begin
      tap_d = st_tlr;
    end
    if (rise) begin
      if (tap_q == st_cap_dr) begin
        unique case (ir_q)
          ID_CODE_INSTR:                dr_d = ID_VALUE;
          COUNTER_SELECT_INSTR:         dr_d = cnt_q;
          CONFIG_REGISTER_SELECT_INSTR: dr_d = {24'h00_0000, done, mode_q[6:0]};
          GROUP_SELECT_INSTR:           dr_d = {30'h0000_0000, group_q};
          default:                      dr_d = 32'h0000_0000;
        endcase
      end
      if (tap_q == st_sh_dr) begin
        for (int i = 0; i < 32; i++) begin
          if (i == dr_len(ir_q) - 1) begin
            dr_d[i] = tdi_s;
          end else if (i < 31) begin
            dr_d[i] = dr_q[i+1];
          end
        end
      end
      if (tap_q == st_upd_dr) begin
        unique case (ir_q)
          COUNTER_SELECT_INSTR: begin
            cnt_d = dr_q;
            run_d = 1'b1;
          end
          CONFIG_REGISTER_SELECT_INSTR: mode_d = {3'b000, dr_q[4:0]};
          GROUP_SELECT_INSTR:           group_d = dr_q[1:0];
          default: ;
        endcase
      end else if (cnt_en_q && run_q && cnt_q != COUNT_RST) begin
        cnt_d = cnt_q - 32'h0000_0001;
      end
      if (tap_q == st_cap_ir) begin
        irs_d = IR_CAPTURE;
      end
      if (tap_q == st_sh_ir) begin
        irs_d = {tdi_s, irs_q[7:1]};
      end
      if (tap_q == st_upd_ir) begin
        ir_d = irs_q;
        if (irs_q == COUNTER_ENABLE_INSTR) begin
          cnt_en_d = 1'b1;
        end
        if (irs_q == COUNTER_DISABLE_INSTR) begin
          cnt_en_d = 1'b0;
          run_d    = 1'b0;
        end
      end
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (tap_q == st_upd_ir) begin
          unique case (irs_q)
            PARK_IN_IDLE_INSTR, PARK_IN_PAUSE_DR_INSTR, PARK_IN_PAUSE_IR_INSTR: begin
              if (pc_q[i] != pc_parked) begin
                pc_d[i]   = pc_parked;
                park_d[i] = (irs_q == PARK_IN_IDLE_INSTR) ? st_rti :
                            (irs_q == PARK_IN_PAUSE_DR_INSTR) ? st_pa_dr : st_pa_ir;
              end
            end
            PARK_IN_RESET_INSTR: begin
              // A port parked elsewhere must be released first
              if (sel[i] && (pc_q[i] != pc_parked || park_q[i] == st_tlr)) begin
                pc_d[i]   = pc_parked;
                park_d[i] = st_tlr;
              end
            end
            LOCAL_PORTS_RESET_INSTR: begin
              pc_d[i]   = pc_parked;
              park_d[i] = st_tlr;
            end
            RELEASE_INSTR: begin
              if (sel[i] && pc_q[i] == pc_parked) begin
                pc_d[i] = (park_q[i] == st_tlr) ? pc_wait_idle : pc_wait_sync;
              end
            end
            default: ;
          endcase
        end else if (pc_q[i] == pc_wait_idle && tap_q == st_rti) begin
          pc_d[i] = pc_active;
        end else if (pc_q[i] == pc_wait_sync && tap_q == park_q[i]) begin
          pc_d[i] = pc_active;
        end
      end
    end
    if (fall) begin
      tdo_d = (tap_q == st_sh_dr) ? dr_q[0] : (tap_q == st_sh_ir) ? irs_q[0] : 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        hold_d[i] = (pc_q[i] != pc_wait_idle);
      end
    end
    if (tap_q == st_tlr) begin
      ir_d     = INSTR_RST;
      mode_d   = MODE_RST;
      group_d  = GROUP_RST;
      lfsr_d   = LFSR_RST;
      cnt_d    = COUNT_RST;
      cnt_en_d = 1'b0;
      run_d    = 1'b0;
      // Chains must see reset at once, not only at the next test clock fall
      hold_d   = '1;
      tdo_d    = 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        pc_d[i]   = pc_parked;
        park_d[i] = st_tlr;
      end
    end
  end

  // ****************************************
  // Local port pins
  // ****************************************
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      // Active ports follow the backplane select directly
      tms_l_d[i] = (pc_q[i] == pc_active) ? tms_s : hold_q[i];
      // Clock gating only applies to parked ports
      tck_l_d[i] = tck_s & ~((pc_q[i] == pc_parked) &&
                             (done || mode_q[MODE_TCK_STOP_BIT]));
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s1_q       <= 4'h0;
      s2_q       <= 4'h0;
      tck_prev_q <= 1'b0;
      tap_q      <= st_tlr;
      ir_q       <= INSTR_RST;
      irs_q      <= 8'h00;
      dr_q       <= 32'h0000_0000;
      mode_q     <= MODE_RST;
      group_q    <= GROUP_RST;
      lfsr_q     <= LFSR_RST;
      cnt_q      <= COUNT_RST;
      cnt_en_q   <= 1'b0;
      run_q      <= 1'b0;
      tdo_q      <= 1'b0;
      hold_q     <= '1;
      tms_l_q    <= '1;
      tck_l_q    <= '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        pc_q[i]   <= pc_parked;
        park_q[i] <= st_tlr;
      end
    end else begin
      s1_q       <= {link.trst_n, link.tdi, link.tms, link.tck};
      s2_q       <= s1_q;
      tck_prev_q <= tck_s;
      tap_q      <= tap_d;
      ir_q       <= ir_d;
      irs_q      <= irs_d;
      dr_q       <= dr_d;
      mode_q     <= mode_d;
      group_q    <= group_d;
      lfsr_q     <= lfsr_d;
      cnt_q      <= cnt_d;
      cnt_en_q   <= cnt_en_d;
      run_q      <= run_d;
      tdo_q      <= tdo_d;
      hold_q     <= hold_d;
      tms_l_q    <= tms_l_d;
      tck_l_q    <= tck_l_d;
      pc_q       <= pc_d;
      park_q     <= park_d;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      port_active_out[i] = (pc_q[i] == pc_active);
    end
  end

  assign link.tdo   = tdo_q;
  assign link.tms_l = tms_l_q;
  assign link.tck_l = tck_l_q;
  assign instr_out  = ir_q;
  assign mode_out   = {done, mode_q[6:0]};

endmodule  // scan_bridge_local_port_control

// File: design/scan_test_master.sv
// Purpose: Backplane test master shifting TMS and TDI patterns from registers
// Assumes: Software follows the documented instruction sequences
// Notes:   Test clock is divided from clk_in and idles low
`timescale 1ns/1ns
module scan_test_master
  import scan_bridge_pkg::*;
#(
  parameter int HALF_CYCLES = TCK_HALF_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  scan_link_if.master      link
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0] tms_sh_q, tms_sh_d;
  logic [31:0] tdi_sh_q, tdi_sh_d;
  logic [31:0] tdo_q,    tdo_d;
  logic [5:0]  len_q,    len_d;
  logic [5:0]  idx_q,    idx_d;
  logic [7:0]  ph_q,     ph_d;
  logic        busy_q,   busy_d;
  logic        trst_q,   trst_d;
  logic        tck_q,    tck_d;
  logic        tms_q,    tms_d;
  logic        tdi_q,    tdi_d;
  logic [31:0] rdata_q,  rdata_d;
  logic        tdo_s1_q;
  logic        tdo_s2_q;

  localparam logic [7:0] PH_HIGH = 8'(HALF_CYCLES);
  localparam logic [7:0] PH_LAST = 8'(2 * HALF_CYCLES - 1);

  always_comb begin
    tms_sh_d = tms_sh_q;
    tdi_sh_d = tdi_sh_q;
    tdo_d    = tdo_q;
    len_d    = len_q;
    idx_d    = idx_q;
    ph_d     = ph_q;
    busy_d   = busy_q;
    trst_d   = trst_q;
    tck_d    = tck_q;
    tms_d    = tms_q;
    tdi_d    = tdi_q;
    rdata_d  = 32'h0000_0000;
    if (wr_in && !busy_q) begin
      unique case (addr_in)
        REG_TMS: tms_sh_d = wdata_in;
        REG_TDI: tdi_sh_d = wdata_in;
        REG_CTRL: begin
          trst_d = wdata_in[CTRL_TRST_BIT];
          if (wdata_in[CTRL_START_BIT]) begin
            len_d  = wdata_in[5:0];
            idx_d  = 6'h00;
            ph_d   = 8'h00;
            busy_d = 1'b1;
            tdo_d  = 32'h0000_0000;
          end
        end
        default: ;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        REG_TMS:    rdata_d = tms_sh_q;
        REG_TDI:    rdata_d = tdi_sh_q;
        REG_CTRL:   rdata_d = {22'h00_0000, trst_q, 3'b000, len_q};
        REG_STATUS: rdata_d = {31'h0000_0000, busy_q};
        REG_TDO:    rdata_d = tdo_q;
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
    if (busy_q) begin
      if (ph_q == 8'h00) begin
        tck_d = 1'b0;
        tms_d = tms_sh_q[idx_q[4:0]];
        tdi_d = tdi_sh_q[idx_q[4:0]];
      end
      if (ph_q == PH_HIGH) begin
        tck_d = 1'b1;
      end
      if (ph_q == PH_LAST) begin
        // Sampling at the end of the high phase leaves the bridge time to settle
        tdo_d[idx_q[4:0]] = tdo_s2_q;
        tck_d = 1'b0;
        ph_d  = 8'h00;
        idx_d = idx_q + 6'h01;
        if (idx_q == len_q) begin
          busy_d = 1'b0;
        end
      end else begin
        ph_d = ph_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tms_sh_q <= 32'h0000_0000;
      tdi_sh_q <= 32'h0000_0000;
      tdo_q    <= 32'h0000_0000;
      len_q    <= 6'h00;
      idx_q    <= 6'h00;
      ph_q     <= 8'h00;
      busy_q   <= 1'b0;
      trst_q   <= 1'b0;
      tck_q    <= 1'b0;
      tms_q    <= 1'b1;
      tdi_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      tdo_s1_q <= 1'b0;
      tdo_s2_q <= 1'b0;
    end else begin
      tms_sh_q <= tms_sh_d;
      tdi_sh_q <= tdi_sh_d;
      tdo_q    <= tdo_d;
      len_q    <= len_d;
      idx_q    <= idx_d;
      ph_q     <= ph_d;
      busy_q   <= busy_d;
      trst_q   <= trst_d;
      tck_q    <= tck_d;
      tms_q    <= tms_d;
      tdi_q    <= tdi_d;
      rdata_q  <= rdata_d;
      tdo_s1_q <= link.tdo;
      tdo_s2_q <= tdo_s1_q;
    end
  end

  assign link.tck    = tck_q;
  assign link.tms    = tms_q;
  assign link.tdi    = tdi_q;
  assign link.trst_n = ~trst_q;
  assign rdata_out   = rdata_q;

endmodule  // scan_test_master

// File: tb/scan_bridge_properties.sv
// Purpose: Assertions on the backplane and local scan pins
// Assumes: Master divider of 4 clk per half test clock
// Notes:   Sees only link wires, so bridge state is inferred from tms
`timescale 1ns/1ns
module scan_bridge_properties #(
  parameter int NUM_PORTS = 3
) (
  input wire logic                 clk_in,
  input wire logic                 reset_n_in,
  input wire logic                 tck,
  input wire logic                 tms,
  input wire logic                 tdo,
  input wire logic                 trst_n,
  input wire logic [NUM_PORTS-1:0] tck_l,
  input wire logic [NUM_PORTS-1:0] tms_l
);
  // ****************************************
  // Rises of the test clock with tms high
  // ****************************************
  logic       tck_q;
  logic       tck_d;
  logic [2:0] ones_q;
  logic [2:0] ones_d;

  always_comb begin
    tck_d = tck;
    ones_d = ones_q;
    if (tck && !tck_q) begin
      ones_d = !tms ? 3'h0 : (ones_q == 3'h7) ? ones_q : ones_q + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tck_q  <= 1'b0;
      ones_q <= 3'h0;
    end else begin
      tck_q  <= tck_d;
      ones_q <= ones_d;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_trst_parks: assert property ($fell(trst_n) |-> ##[1:6] tms_l == '1)
    else $error("ports not parked after test reset");
  a_trst_holds: assert property (!trst_n [*6] |-> tms_l == '1 && tdo == 1'b0)
    else $error("ports or tdo disturbed in test reset");
  a_five_ones: assert property (ones_q == 3'h5 |-> ##[0:6] tms_l == '1)
    else $error("five tms high clocks did not reset ports");
  a_reset_values: assert property ($rose(reset_n_in) |-> tms_l == '1 && tck_l == '0)
    else $error("local pins wrong after reset");
  a_tck_high_len: assert property ($rose(tck) |-> tck [*3])
    else $error("test clock high phase too short");
  a_tck_low_len: assert property ($fell(tck) |-> !tck [*3])
    else $error("test clock low phase too short");
  a_tms_l_fall: assert property ($fell(tms_l[0]) |-> !tck || !$past(tck))
    else $error("local mode select fell outside low test clock");
  a_tck_l_pulse: assert property ($rose(tck_l[0]) |-> ##[1:5] !tck_l[0])
    else $error("local clock stuck high");
endmodule // scan_bridge_properties

// File: tb/scan_bridge_local_port_control_test.sv
// Purpose: Self-checking bench joining the test master and the bridge
// Assumes: Master divider of 4 clk per half test clock
// Notes:   All traffic goes through the master's register port
`timescale 1ns/1ns
module scan_bridge_local_port_control_test;
  import scan_bridge_pkg::*;
  logic        clk_in;
  logic        reset_n_in;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [7:0]  instr;
  logic [7:0]  mode;
  logic [2:0]  act;
  logic [31:0] q;
  logic [7:0]  prev;
  logic [7:0]  mw;
  logic [2:0]  off;
  int          bad_count;
  int          checked;

  scan_link_if #(.NUM_PORTS(3)) link ();
  scan_test_master #(.HALF_CYCLES(4)) scan_test_master_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .link(link.master));
  scan_bridge_local_port_control #(.NUM_PORTS(3)) scan_bridge_local_port_control_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .link(link.bridge), .instr_out(instr),
    .mode_out(mode), .port_active_out(act));
  scan_bridge_properties #(.NUM_PORTS(3)) scan_bridge_properties_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .tck(link.tck), .tms(link.tms),
    .tdo(link.tdo), .trst_n(link.trst_n), .tck_l(link.tck_l), .tms_l(link.tms_l));

  // ****************************************
  // Bus, scan and compare tasks
  // ****************************************
  function automatic logic [7:0] exp_mode(input logic [7:0] w, input logic done);
    return {done, 2'b00, w[4:0]};
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Bit 0 goes out first; the bridge needs a few clk after the last edge
  task automatic shift(input logic [31:0] t, input logic [31:0] d, input int n);
    int k;
    wr_reg(REG_TMS, t);
    wr_reg(REG_TDI, d);
    wr_reg(REG_CTRL, 32'h0000_0100 | 32'(n - 1));
    k = 0;
    do begin
      rd_reg(REG_STATUS, q);
      k++;
    end while (q[0] !== 1'b0 && k < 500);
    check("busy", 32'h0, {31'h0, q[0]});
    rd_reg(REG_TDO, q);
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  // From idle through Shift-IR; ends in idle, or in Select-DR when sel is set
  task automatic load_ir(input logic [7:0] code, input logic sel);
    shift(32'h0000_1803 | {18'h0, sel, 13'h0}, {20'h0, code, 4'h0}, 14);
    check("ir capture", IR_CAPTURE, q[11:4]);
    check("instr", code, instr);
  endtask

  task automatic mode_scan(input logic [7:0] w, input logic done);
    load_ir(CONFIG_REGISTER_SELECT_INSTR, 1'b0);
    shift(32'h0000_0C01, {21'h0, w, 3'h0}, 13);
    check("mode capture", exp_mode(prev, done), q[10:3]);
    check("mode", exp_mode(w, done), mode);
    prev = w;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim();
  end

  initial begin
    reset_n_in = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    bad_count = 0;
    checked = 0;
    prev = MODE_RST;
    void'($urandom(21284));
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check("reset instr", INSTR_RST, instr);
    check("reset mode", MODE_RST, mode);
    check("reset tms_l", 3'h7, link.tms_l);
    $display("reset test done");
    shift(32'h0, 32'h0, 1);
    for (int i = 0; i < 2; i++) begin
      mw = (i == 0) ? 8'h07 : 8'($urandom_range(1, 7));
      mode_scan(mw, 1'b0);
      off = ~mw[2:0];
      load_ir(RELEASE_INSTR, 1'b1);
      check("early tms_l", off, link.tms_l);
      check("early active", 3'h0, act);
      shift(32'h0000_0006, 32'h0, 5);
      check("active", mw[2:0], act);
      check("tms_l", off, link.tms_l);
      load_ir(PARK_IN_RESET_INSTR, 1'b0);
      check("park active", 3'h0, act);
      check("park tms_l", 3'h7, link.tms_l);
      $display("release test %0d done", i);
    end
    load_ir(RELEASE_INSTR, 1'b0);
    shift(32'h0, 32'h0, 2);
    check("active", mw[2:0], act);
    load_ir(PARK_IN_PAUSE_DR_INSTR, 1'b0);
    check("pause tms_l", 3'h7, link.tms_l);
    load_ir(RELEASE_INSTR, 1'b0);
    shift(32'h0, 32'h0, 2);
    check("sync wait", 3'h0, act);
    shift(32'h0000_0005, 32'h0, 5);
    check("sync active", mw[2:0], act);
    shift(32'h0000_0003, 32'h0, 3);
    load_ir(LOCAL_PORTS_RESET_INSTR, 1'b0);
    check("soft tms_l", 3'h7, link.tms_l);
    check("soft active", 3'h0, act);
    $display("local reset test done");
    load_ir(COUNTER_ENABLE_INSTR, 1'b0);
    load_ir(COUNTER_SELECT_INSTR, 1'b0);
    shift(32'h1, 32'h0, 3);
    // 58 counted rises pass before the stop check, so the count must end first
    shift(32'h8000_0000, 32'($urandom_range(40, 56)), 32);
    shift(32'h1, 32'h0, 2);
    mode_scan(prev, 1'b0);
    shift(32'h0, 32'h0, 32);
    fork
      shift(32'h0, 32'h0, 32);
      begin
        @(posedge link.tck);
        repeat (3) @(posedge clk_in);
        #1 check("stopped tck_l", 3'h0, link.tck_l);
      end
    join
    check("done mode", exp_mode(prev, 1'b1), mode);
    mode_scan(prev, 1'b1);
    load_ir(COUNTER_DISABLE_INSTR, 1'b0);
    check("done off", 1'b0, mode[7]);
    $display("counter test done");
    load_ir(COUNTER_SELECT_INSTR, 1'b0);
    shift(32'h1, 32'h0, 3);
    shift(32'h8000_0000, 32'($urandom) | 32'h1, 32);
    shift(32'h1, 32'h0, 2);
    shift(32'h0000_001F, 32'h0, 5);
    check("tlr instr", INSTR_RST, instr);
    check("tlr mode", MODE_RST, mode);
    check("tlr tms_l", 3'h7, link.tms_l);
    shift(32'h0, 32'h0, 1);
    load_ir(COUNTER_SELECT_INSTR, 1'b0);
    shift(32'h1, 32'h0, 3);
    shift(32'h8000_0000, 32'h0, 32);
    check("tlr count", COUNT_RST, q);
    shift(32'h1, 32'h0, 2);
    load_ir(CONFIG_REGISTER_SELECT_INSTR, 1'b0);
    wr_reg(REG_CTRL, 32'h0000_0200);
    repeat (8) @(posedge clk_in);
    wr_reg(REG_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk_in);
    #1 check("trst instr", INSTR_RST, instr);
    $display("reset level test done");
    end_sim();
  end
endmodule // scan_bridge_local_port_control_test
